//--- hdl/lad_core.sv
`timescale 1ns/1ns

// Contract
// - Report locality as one-hot indicator value
// - Highest requesting locality number wins grant
// - Free state accepts locality-4 hash/control writes
// - Locality-bound resources need permitted locality
// - Per-locality status copies share one register
// - Whole data port range aliases one register
// - Hash addresses decode only in locality 4
// - Per-locality copies sit in separate ranges
// - Respond across whole register range
// - Locality 4 highest, carries hash commands
// - Buffer registers in one contiguous space
// - Locality from address bits 15:12
// - Hash start claims locality 4 when free
// - Hash end clears active locality
module lad_core
   import lad_pkg::*;
(
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   // Host bus cycle from the chipset controller
   input  wire lad_pkg::lad_cycle_t cyc,
   // Locality requests from software (held pending until the device is free), one bit per locality
   input  wire logic [4:0]         loc_req,
   // Owner granted from a request gives the device up
   input  wire logic               loc_release,
   // Locality a resource is bound to, as a one-hot indicator
   input  wire logic [7:0]         res_loc_mask,
   // Read data and decode results
   output logic [7:0]              rdata,
   output logic                    cyc_hit,
   output lad_pkg::lad_sel_t       cyc_sel,
   output logic [2:0]              cyc_loc,
   // Ownership and hash events
   output logic [7:0]              active_loc,
   output logic                    loc_free,
   output logic                    hash_start,
   output logic                    hash_data,
   output logic                    hash_end,
   output logic                    data_stb,
   output logic [7:0]              data_byte,
   output logic                    access_permit
);
   import lad_pkg::*;

   lad_st_t  st_r;          // Registered state
   lad_st_t  st_nxt;        // Next state
   lad_dec_t dec;           // Decode of the present cycle
   logic [NUM_LOC-1:0] req_all;  // Pending plus new requests
   logic [7:0] grant_ind;   // Indicator of the winning request
   logic       in_range;    // Offset check helper

   // One-hot indicator for a locality number
   function automatic logic [7:0] loc_ind(input logic [2:0] n);
      loc_ind = IND_LOC0 << n;
   endfunction : loc_ind

   // Offset lies within a closed range
   function automatic logic ofs_in(input logic [11:0] o,
                                   input logic [11:0] lo,
                                   input logic [11:0] hi);
      ofs_in = (o >= lo) && (o <= hi);
   endfunction : ofs_in

   // Address decode: locality nibble, then offset within the window
   always_comb
   begin
      dec.loc = 3'(cyc.addr[LOC_HI:LOC_LO]);
      dec.ofs = cyc.addr[LOC_LO-1:0];
      dec.hit = cyc.valid && (cyc.addr[LOC_HI:LOC_LO] <= LOC_ID_4);
      dec.sel = LAD_SEL_OTHER;
      in_range = 1'b0;
      // Each locality owns its own 4 KB window, adjoining the next locality's window
      if (ofs_in(dec.ofs, OFS_STS_LO, OFS_STS_HI))
      begin
         dec.sel = LAD_SEL_STATUS;
      end
      else if (ofs_in(dec.ofs, OFS_DATA_LO, OFS_DATA_HI) &&
               (cyc.addr[LOC_HI:LOC_LO] != LOC_ID_4))
      begin
         dec.sel = LAD_SEL_DATA;
      end
      else if (dec.ofs == OFS_BUF_CTRL && cyc.addr[LOC_HI:LOC_LO] == LOC_ID_4)
      begin
         dec.sel = LAD_SEL_BUF_CTRL;
      end
      // Hash commands exist only in the locality-4 window
      else if (cyc.addr[LOC_HI:LOC_LO] == LOC_ID_4)
      begin
         in_range = ofs_in(dec.ofs, OFS_HASH_LO, OFS_HASH_HI);
         if (in_range && dec.ofs == OFS_HASH_STA)
         begin
            dec.sel = LAD_SEL_HASH_STA;
         end
         else if (in_range && dec.ofs[11:2] == OFS_HASH_DAT[11:2])
         begin
            dec.sel = LAD_SEL_HASH_DAT;
         end
         else if (in_range && dec.ofs == OFS_HASH_END)
         begin
            dec.sel = LAD_SEL_HASH_END;
         end
      end
      if (!dec.hit)
      begin
         dec.sel = LAD_SEL_NONE;
      end
   end

   // Priority grant: highest locality number among requests wins
   always_comb
   begin
      req_all   = st_r.pend | loc_req;
      grant_ind = IND_NONE;
      for (int i = 0; i < NUM_LOC; i++)
      begin
         if (req_all[i])
         begin
            grant_ind = loc_ind(3'(i));
         end
      end
   end

   // Next-state logic for ownership, hash sequence and shared registers
   always_comb
   begin
      st_nxt            = st_r;
      st_nxt.data_stb   = 1'b0;
      st_nxt.hash_start = 1'b0;
      st_nxt.hash_data  = 1'b0;
      st_nxt.hash_end   = 1'b0;
      st_nxt.cyc_hit    = dec.hit;
      st_nxt.cyc_sel    = dec.sel;
      st_nxt.cyc_loc    = dec.loc;
      st_nxt.pend       = st_r.pend | loc_req;
      // Resource gating: only the owning locality may touch bound resources
      st_nxt.permit     = |(st_r.active & res_loc_mask);

      unique case (st_r.state)
         LAD_ST_FREE:
         begin
            // Free means no indicator bit set
            if (dec.hit && cyc.write &&
                (dec.sel == LAD_SEL_HASH_STA || dec.sel == LAD_SEL_BUF_CTRL))
            begin
               // Locality-4 hash start and buffer control writes always outrank software requests
               st_nxt.state      = LAD_ST_HASH;
               st_nxt.active     = IND_LOC4;
               st_nxt.hash_start = (dec.sel == LAD_SEL_HASH_STA);
            end
            else if (req_all != '0)
            begin
               st_nxt.state  = LAD_ST_OWN;
               st_nxt.active = grant_ind;
               st_nxt.pend   = req_all & ~5'(grant_ind);
            end
         end
         LAD_ST_OWN:
         begin
            // Hash start while another locality owns the device is dropped
            if (loc_release)
            begin
               st_nxt.state  = LAD_ST_FREE;
               st_nxt.active = IND_NONE;
            end
         end
         LAD_ST_HASH:
         begin
            // Only locality-4 writes drive the sequence; trust host gating
            if (dec.hit && cyc.write && dec.sel == LAD_SEL_HASH_DAT)
            begin
               st_nxt.hash_data = 1'b1;
               st_nxt.data      = cyc.wdata;
            end
            else if (dec.hit && cyc.write && dec.sel == LAD_SEL_HASH_STA)
            begin
               st_nxt.hash_start = 1'b1;
            end
            else if (dec.hit && cyc.write && dec.sel == LAD_SEL_HASH_END)
            begin
               st_nxt.hash_end = 1'b1;
               st_nxt.state    = LAD_ST_FREE;
               st_nxt.active   = IND_NONE;
            end
         end
         default:
         begin
            st_nxt.state  = LAD_ST_FREE;
            st_nxt.active = IND_NONE;
         end
      endcase

      // Shared status and data registers, owner locality only
      if (dec.hit && cyc.write && (st_r.active == loc_ind(dec.loc)))
      begin
         if (dec.sel == LAD_SEL_STATUS)
         begin
            st_nxt.status = cyc.wdata;
         end
         else if (dec.sel == LAD_SEL_DATA)
         begin
            st_nxt.data     = cyc.wdata;
            st_nxt.data_stb = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Read mux: status mirrors are one register, data port reads the data register, others read as zero
   always_comb
   begin
      rdata = IND_NONE;
      if (st_r.cyc_sel == LAD_SEL_STATUS)
      begin
         rdata = st_r.status;
      end
      else if (st_r.cyc_sel == LAD_SEL_DATA)
      begin
         rdata = st_r.data;
      end
   end

   // Outputs
   assign cyc_hit       = st_r.cyc_hit;
   assign cyc_sel       = st_r.cyc_sel;
   assign cyc_loc       = st_r.cyc_loc;
   assign active_loc    = st_r.active;
   assign loc_free      = (st_r.active == IND_NONE);
   assign hash_start    = st_r.hash_start;
   assign hash_data     = st_r.hash_data;
   assign hash_end      = st_r.hash_end;
   assign data_stb      = st_r.data_stb;
   assign data_byte     = st_r.data;
   assign access_permit = st_r.permit;

endmodule : lad_core

//--- inc/lad_pkg.sv
package lad_pkg;

   // Address and locality geometry
   localparam int ADDR_W            = 16;
   localparam int LOC_HI            = 15;
   localparam int LOC_LO            = 12;
   localparam int NUM_LOC           = 5;
   localparam int IND_W             = 8;

   // Locality nibble values
   localparam logic [3:0] LOC_ID_0  = 4'h0;
   localparam logic [3:0] LOC_ID_4  = 4'h4;

   // One-hot locality indicator values
   localparam logic [7:0] IND_NONE  = 8'h00;
   localparam logic [7:0] IND_LOC0  = 8'h01;
   localparam logic [7:0] IND_LOC4  = 8'h10;

   // Register offsets within a locality window (low 12 bits)
   localparam logic [11:0] OFS_STS_LO   = 12'h018;
   localparam logic [11:0] OFS_STS_HI   = 12'h01b;
   localparam logic [11:0] OFS_DATA_LO  = 12'h024;
   localparam logic [11:0] OFS_DATA_HI  = 12'h027;
   localparam logic [11:0] OFS_HASH_LO  = 12'h020;
   localparam logic [11:0] OFS_HASH_END = 12'h020;
   localparam logic [11:0] OFS_HASH_DAT = 12'h024;
   localparam logic [11:0] OFS_HASH_STA = 12'h028;
   localparam logic [11:0] OFS_HASH_HI  = 12'h028;
   localparam logic [11:0] OFS_BUF_CTRL = 12'h008;

   // Register selection produced by decode
   typedef enum logic [2:0]
   {
      LAD_SEL_NONE     = 3'b000,
      LAD_SEL_STATUS   = 3'b001,
      LAD_SEL_DATA     = 3'b010,
      LAD_SEL_HASH_STA = 3'b011,
      LAD_SEL_HASH_DAT = 3'b100,
      LAD_SEL_HASH_END = 3'b101,
      LAD_SEL_BUF_CTRL = 3'b110,
      LAD_SEL_OTHER    = 3'b111
   } lad_sel_t;

   // Ownership state
   typedef enum logic [1:0]
   {
      LAD_ST_FREE = 2'b00,
      LAD_ST_OWN  = 2'b01,
      LAD_ST_HASH = 2'b10
   } lad_state_t;

   // One host bus cycle
   typedef struct packed
   {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
   } lad_cycle_t;

   // Decode result for the current cycle
   typedef struct packed
   {
      logic              hit;
      logic [2:0]        loc;
      lad_sel_t          sel;
      logic [11:0]       ofs;
   } lad_dec_t;

   // All block state
   typedef struct packed
   {
      lad_state_t        state;
      logic [IND_W-1:0]  active;
      logic [NUM_LOC-1:0] pend;
      logic [IND_W-1:0]  status;
      logic [IND_W-1:0]  data;
      logic              data_stb;
      logic              hash_start;
      logic              hash_data;
      logic              hash_end;
      logic              permit;
      logic              cyc_hit;
      lad_sel_t          cyc_sel;
      logic [2:0]        cyc_loc;
   } lad_st_t;

endpackage : lad_pkg

//--- tb/lad_props.sv
`timescale 1ns/1ns
module lad_props
(
   // Clock, reset
   input wire logic                sys_clk,
   input wire logic                sys_rst,
   // Inputs
   input wire lad_pkg::lad_cycle_t cyc,
   input wire logic                loc_release,
   input wire logic [7:0]          res_loc_mask,
   // Outputs
   input wire logic                cyc_hit,
   input wire lad_pkg::lad_sel_t   cyc_sel,
   input wire logic [2:0]          cyc_loc,
   input wire logic [7:0]          active_loc,
   input wire logic                loc_free,
   input wire logic                hash_start,
   input wire logic                hash_end,
   input wire logic                access_permit
);
   import lad_pkg::*;
   wire [3:0]  nib = cyc.addr[15:12];
   wire [11:0] ofs = cyc.addr[11:0];
   // Locality-4 hash start write
   wire        wr4 = cyc.valid && cyc.write && cyc.addr == 16'h4028;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_ind_onehot:
      assert property ($onehot0(active_loc) && active_loc[7:5] == 3'h0) else $error("not one-hot");
   a_free_flag:
      assert property (loc_free == (active_loc == 8'h00)) else $error("free flag wrong");
   a_hash_claim:
      assert property (wr4 && loc_free |=> hash_start && active_loc == 8'h10)
      else $error("hash start not claimed");
   a_hash_ignored:
      assert property (wr4 && !loc_free && active_loc != 8'h10 && !loc_release
         |=> !hash_start && $stable(active_loc)) else $error("hash start not ignored");
   a_end_frees:
      assert property (hash_end |-> loc_free) else $error("hash end kept owner");
   a_loc_decode:
      assert property (cyc.valid && nib <= 4'h4 |=> cyc_hit && cyc_loc == $past(cyc.addr[14:12]))
      else $error("locality decode wrong");
   a_loc_nohit:
      assert property (cyc.valid && nib > 4'h4 |=> !cyc_hit) else $error("hit above 4");
   a_hash_window:
      assert property (cyc.valid && nib < 4'h4 && (ofs == OFS_HASH_END || ofs == OFS_HASH_STA)
         |=> cyc_sel == LAD_SEL_OTHER && !hash_start && !hash_end) else $error("hash below 4");
   a_data_alias:
      assert property (cyc.valid && nib < 4'h4 && ofs[11:2] == OFS_DATA_LO[11:2]
         |=> cyc_sel == LAD_SEL_DATA) else $error("data alias wrong");
   a_status_alias:
      assert property (cyc.valid && nib < 4'h4 && ofs[11:2] == OFS_STS_LO[11:2]
         |=> cyc_sel == LAD_SEL_STATUS) else $error("status alias wrong");
   a_permit_lag:
      assert property (access_permit == |($past(active_loc) & $past(res_loc_mask)))
      else $error("permit wrong");
   c_hash: cover property (hash_start);
   c_loc3: cover property (active_loc == 8'h08);
   c_permit: cover property (access_permit);
endmodule : lad_props

//--- tb/lad_host_model.sv
`timescale 1ns/1ns
module lad_host_model
(
   // Clock, reset
   input  wire logic                sys_clk,
   input  wire logic                sys_rst,
   // Requested cycle, origin high for software
   input  wire lad_pkg::lad_cycle_t req,
   input  wire logic                sw_origin,
   // Cycle to the device
   output lad_pkg::lad_cycle_t      cyc
);
   import lad_pkg::*;
   // Forward one clock later, dropping software cycles to locality 4; idle address and data lines toggle so stale values never look held
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         cyc <= '0;
      else if (req.valid && !(sw_origin && req.addr[15:12] == 4'h4))
         cyc <= req;
      else
      begin
         cyc.valid <= 1'b0;
         cyc.addr  <= ~cyc.addr;
         cyc.wdata <= ~cyc.wdata;
      end
   end
endmodule : lad_host_model

//--- tb/test_locality_arbiter_decode.sv
`timescale 1ns/1ns
module test_locality_arbiter_decode;
   import lad_pkg::*;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, sw_origin = 1'b0, loc_release = 1'b0;
   lad_cycle_t  req = '0, cyc;
   logic [4:0]  loc_req = 5'h00;
   logic [7:0]  res_loc_mask = 8'h00, rdata, active_loc, data_byte, prev_act;
   logic        cyc_hit, loc_free, hash_start, hash_data, hash_end, data_stb, access_permit;
   lad_sel_t    cyc_sel;
   logic [2:0]  cyc_loc;
   logic [31:0] rnd = 32'h22cd7662;
   logic [11:0] ofs_tab [4] = '{12'h018, 12'h020, 12'h024, 12'h028};
   logic [7:0]  exp_act[$], exp_byte[$];
   int          miscompares = 0, compares = 0;
   lad_host_model lad_host_model_inst (.sys_clk, .sys_rst, .req, .sw_origin, .cyc);
   lad_core lad_core_inst (.sys_clk, .sys_rst, .cyc, .loc_req, .loc_release, .res_loc_mask,
      .rdata, .cyc_hit, .cyc_sel, .cyc_loc, .active_loc, .loc_free, .hash_start, .hash_data,
      .hash_end, .data_stb, .data_byte, .access_permit);
   always #5 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check8
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, input logic sw);
      @(posedge sys_clk);
      req       <= '{1'b1, w, a, d};
      sw_origin <= sw;
      @(posedge sys_clk);
      req.valid <= 1'b0;
   endtask : bus
   task automatic pulse(input logic [4:0] r, input logic rel);
      @(posedge sys_clk);
      loc_req     <= r;
      loc_release <= rel;
      @(posedge sys_clk);
      loc_req     <= 5'h00;
      loc_release <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : pulse
   task automatic complete_run;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   // Random resource binding keeps the permit path busy
   always @(posedge sys_clk)
   begin
      rnd          <= lfsr(rnd);
      res_loc_mask <= 8'h01 << (rnd[10:8] % 3'd5);
   end
   // Each new owner and each accepted byte takes the oldest note
   always @(posedge sys_clk)
   begin
      if (!sys_rst && active_loc !== prev_act && active_loc !== 8'h00)
         check8(active_loc, exp_act.size() ? exp_act.pop_front() : 8'hxx);
      if (!sys_rst && (hash_data || data_stb))
         check8(data_byte, exp_byte.size() ? exp_byte.pop_front() : 8'hxx);
      prev_act <= active_loc;
   end
   initial
   begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      bus(1'b1, 16'h4028, 8'h00, 1'b1);
      repeat (2) @(posedge sys_clk);
      check8(active_loc, IND_NONE);
      exp_act.push_back(IND_LOC4);
      bus(1'b1, 16'h4028, 8'h00, 1'b0);
      exp_byte.push_back(rnd[7:0]);
      bus(1'b1, {4'h4, 10'h009, rnd[1:0]}, rnd[7:0], 1'b0);
      bus(1'b1, 16'h4020, 8'h00, 1'b0);
      repeat (2) @(posedge sys_clk);
      check8(active_loc, IND_NONE);
      exp_act.push_back(8'h04);
      pulse(5'b00101, 1'b0);
      bus(1'b1, 16'h4028, 8'h00, 1'b0);
      exp_byte.push_back(rnd[7:0]);
      bus(1'b1, {4'h2, 10'h009, rnd[1:0]}, rnd[7:0], 1'b0);
      bus(1'b1, 16'h0025, 8'h5a, 1'b0);
      // Owner writes its status copy, locality 0 copy reads the same register
      bus(1'b1, 16'h2019, 8'h3c, 1'b0);
      bus(1'b0, 16'h0018, 8'h00, 1'b0);
      repeat (2) @(negedge sys_clk);
      check8(rdata, 8'h3c);
      exp_act.push_back(8'h08);
      exp_act.push_back(8'h02);
      exp_act.push_back(8'h01);
      pulse(5'b01010, 1'b1);
      repeat (3) pulse(5'h00, 1'b1);
      check8(active_loc, IND_NONE);
      // Decode sweep while free; any accepted byte here is a stray
      repeat (60)
         bus(rnd[3], {(rnd[7:4] == 4'h4) ? 4'h5 : rnd[7:4], ofs_tab[rnd[9:8]] | 12'(rnd[1:0])},
            rnd[23:16], 1'b0);
      repeat (4) @(posedge sys_clk);
      check8(8'(exp_act.size() + exp_byte.size()), 8'h00);
      complete_run;
   end
   // Watchdog
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      miscompares++;
      complete_run;
   end
endmodule : test_locality_arbiter_decode
bind lad_core lad_props lad_props_inst (.sys_clk, .sys_rst, .cyc, .loc_release, .res_loc_mask,
   .cyc_hit, .cyc_sel, .cyc_loc, .active_loc, .loc_free, .hash_start, .hash_end, .access_permit);
